// [rtl/cra_pkg.sv]
// package: token codes, destination codes and field sizes of the config access protocol
`default_nettype none
package cra_pkg;
  // control token values
  localparam logic [7:0] CRA_TOK_WRITE = 8'hC0; // write command
  localparam logic [7:0] CRA_TOK_READ = 8'hC1; // read command
  localparam logic [7:0] CRA_TOK_END = 8'h01; // message end
  localparam logic [7:0] CRA_TOK_ACK = 8'h03; // success status
  localparam logic [7:0] CRA_TOK_NAK = 8'h04; // failure status
  // destination low-half codes (peripheral: low byte only)
  localparam logic [15:0] CRA_TILE_CODE = 16'hC20C; // tile configuration
  localparam logic [15:0] CRA_NODE_CODE = 16'hC30C; // node configuration
  localparam logic [7:0] CRA_PERIPH_CODE = 8'h02; // analogue peripheral
  // reply channel number meaning no reply wanted
  localparam logic [7:0] CRA_NOREPLY_CHAN = 8'hFF;
  // processor status resource type and shift
  localparam logic [7:0] CRA_PS_RES_TYPE = 8'h0B;
  localparam int CRA_PS_SHIFT = 8;
  // field lengths in bytes
  localparam int CRA_RID_BYTES = 3;
  localparam int CRA_REG_BYTES = 2;
  localparam int CRA_DATA_BYTES = 4;
  // message token counts (last index)
  localparam logic [3:0] CRA_WR_LAST = 4'hA; // cmd, 3 rid, 2 reg, 4 data, end
  localparam logic [3:0] CRA_RD_LAST = 4'h6; // cmd, 3 rid, 2 reg, end
  localparam logic [2:0] CRA_RSP_LONG_LAST = 3'h5; // status, 4 data, end
  localparam logic [2:0] CRA_RSP_SHORT_LAST = 3'h1; // status, end
  // register bank selected by a destination
  typedef enum logic [1:0] {CRA_BANK_TILE, CRA_BANK_NODE, CRA_BANK_PERIPH, CRA_BANK_NONE} cra_bank_t;
endpackage : cra_pkg
`default_nettype wire

// [rtl/cra_link_if.sv]
// interface: token streams between requester and configuration handler
`default_nettype none
interface cra_link_if;
  logic req_valid; // request token offered
  logic req_ready; // request token taken
  logic req_ctrl; // request token is a control token
  logic [7:0] req_data; // request token value
  logic [31:0] req_dest; // destination of the request channel
  logic rsp_valid; // reply token offered
  logic rsp_ready; // reply token taken
  logic rsp_ctrl; // reply token is a control token
  logic [7:0] rsp_data; // reply token value
  logic [23:0] rsp_dest; // reply channel-end identifier
  modport dev (
    input req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
  modport host (
    output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
endinterface : cra_link_if
`default_nettype wire

// [rtl/cra_dev.sv]
// module: configuration register handler, the device end of the link
//
// How it works
// [RULE1] requests carry upper 24 reply id bits
// [RULE2] reply id is node id then channel
// [RULE3] write with low byte all ones: no reply
// [RULE4] multi-byte fields go most significant byte first
// [RULE5] status resource id is reg shifted, OR 0x0B
// [RULE6] tile destination: tile id, tile code
// [RULE7] node destination: node id, node code
// [RULE8] peripheral destination: node, peripheral, byte 02
// [RULE9] write: 192, reply id, reg, data, 1
// [RULE10] write reply: 3,1 success or 4,1 failure
// [RULE11] config read reply: 3, word, 1 or 4,1
// [RULE12] peripheral read reply: 3, data, 1 or 4,1
// [RULE13] read: read token, reply id, reg, 1
// [RULE14] bad register or message: no change, fail reply (no reply when the reply id is incomplete)
`default_nettype none
module cra_dev
  import cra_pkg::*;
#(
  parameter int NREG = 16, // registers per bank
  parameter logic [7:0] PERIPH_ID = 8'h01 // peripheral number served
) (
  input wire logic core_clk_in, // system clock
  input wire logic srst_in, // synchronous reset, high
  cra_link_if.dev link, // token link to requester
  input wire logic [15:0] tile_id_in, // own tile identifier
  input wire logic [15:0] node_id_in, // own node identifier
  output logic [3*NREG*32-1:0] regs_out, // all bank contents, tile first
  output logic busy_out // a message is in progress
);
  import cra_pkg::*;

  // message parser states
  typedef enum logic [2:0] {
    CRA_ST_IDLE, CRA_ST_RID, CRA_ST_REG, CRA_ST_DATA, CRA_ST_END, CRA_ST_SKIP, CRA_ST_REPLY
  } cra_dev_state_t;

  localparam int IW = $clog2(3 * NREG); // storage index width

  cra_dev_state_t state_q; // parser state
  logic [1:0] cnt_q; // byte count inside a field
  logic is_wr_q; // message is a write
  logic rid_ok_q; // whole reply id received
  cra_bank_t bank_q; // bank decoded from destination
  logic [23:0] rid_q; // reply channel-end id
  logic [15:0] reg_q; // register number
  logic [31:0] wdata_q; // write data
  logic [31:0] rdata_q; // read data for reply
  logic rsp_ok_q; // reply is success
  logic rsp_rd_q; // reply carries data
  logic [2:0] rsp_idx_q; // reply token index
  logic [8:0] rsp_tok_q; // reply token {ctrl, value}
  logic [23:0] rsp_dest_q; // reply destination
  logic [31:0] mem_q [0:3*NREG-1]; // register storage
  logic acc; // request token taken
  logic rsp_acc; // reply token taken
  logic is_end; // token is the end control token
  logic fin; // message finished this cycle
  logic fin_good; // finished and well formed
  logic fin_ok; // finished and will succeed
  logic fin_reply; // a reply is to be sent
  logic [IW-1:0] mem_idx; // storage index of the request

  // decode destination into a bank
  function automatic cra_bank_t bank_of(input logic [31:0] dest, input logic [15:0] tile,
                                        input logic [15:0] node);
    if (dest[31:16] == tile && dest[15:0] == CRA_TILE_CODE) // see [RULE6]
      return CRA_BANK_TILE;
    else if (dest[31:16] == node && dest[15:0] == CRA_NODE_CODE) // see [RULE7]
      return CRA_BANK_NODE;
    else if (dest[31:16] == node && dest[15:8] == PERIPH_ID && dest[7:0] == CRA_PERIPH_CODE)
      return CRA_BANK_PERIPH; // see [RULE8]
    else
      return CRA_BANK_NONE;
  endfunction : bank_of

  // reply token at a given index
  function automatic logic [8:0] rsp_tok(input logic [2:0] idx, input logic ok,
                                         input logic rd, input logic [31:0] data);
    if (idx == 3'h0)
      return {1'b1, ok ? CRA_TOK_ACK : CRA_TOK_NAK}; // see [RULE10] [RULE11] [RULE12]
    else if (ok && rd && idx <= 3'h4)
      return {1'b0, data[31 - 8 * (int'(idx) - 1) -: 8]}; // see [RULE4] [RULE11] [RULE12]
    else
      return {1'b1, CRA_TOK_END};
  endfunction : rsp_tok

  // handshakes and finish decode
  assign acc = link.req_valid && link.req_ready;
  assign rsp_acc = link.rsp_valid && link.rsp_ready;
  assign is_end = link.req_ctrl && link.req_data == CRA_TOK_END;
  assign mem_idx = IW'(int'(bank_q) * NREG + int'(reg_q));

  // end of message: well formed only in the end state
  always_comb
  begin
    fin = 1'b0;
    fin_good = 1'b0;
    if (acc && is_end && state_q != CRA_ST_IDLE && state_q != CRA_ST_REPLY)
    begin
      fin = 1'b1;
      fin_good = state_q == CRA_ST_END;
    end
    // unknown bank or register fails, see [RULE14]
    fin_ok = fin_good && bank_q != CRA_BANK_NONE && reg_q < 16'(NREG);
    // write to a channel ending in all ones gets no reply, see [RULE3]
    fin_reply = fin && rid_ok_q && !(is_wr_q && rid_q[7:0] == CRA_NOREPLY_CHAN);
  end

  // link outputs
  assign link.req_ready = state_q != CRA_ST_REPLY;
  assign link.rsp_valid = state_q == CRA_ST_REPLY;
  assign link.rsp_ctrl = rsp_tok_q[8];
  assign link.rsp_data = rsp_tok_q[7:0];
  assign link.rsp_dest = rsp_dest_q; // see [RULE2]
  assign busy_out = state_q != CRA_ST_IDLE;

  // parser state machine
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state_q <= CRA_ST_IDLE;
      cnt_q <= 2'h0;
    end
    else if (fin)
    begin
      state_q <= fin_reply ? CRA_ST_REPLY : CRA_ST_IDLE;
      cnt_q <= 2'h0;
    end
    else if (state_q == CRA_ST_REPLY)
    begin
      // leave once the last reply token is taken
      if (rsp_acc && rsp_idx_q == (rsp_rd_q && rsp_ok_q ? CRA_RSP_LONG_LAST : CRA_RSP_SHORT_LAST))
        state_q <= CRA_ST_IDLE;
    end
    else if (acc)
    begin
      unique case (state_q)
        // command token opens a message, see [RULE9] [RULE13]
        CRA_ST_IDLE:
        begin
          if (link.req_ctrl && (link.req_data == CRA_TOK_WRITE || link.req_data == CRA_TOK_READ))
            state_q <= CRA_ST_RID;
          else if (!is_end)
            state_q <= CRA_ST_SKIP; // stray token, see [RULE14]
        end
        // field bytes: a control token here is malformed
        CRA_ST_RID, CRA_ST_REG, CRA_ST_DATA:
        begin
          if (link.req_ctrl)
          begin
            state_q <= CRA_ST_SKIP; // see [RULE14]
            cnt_q <= 2'h0;
          end
          else if (state_q == CRA_ST_RID && cnt_q == 2'(CRA_RID_BYTES - 1))
          begin
            state_q <= CRA_ST_REG; // see [RULE1]
            cnt_q <= 2'h0;
          end
          else if (state_q == CRA_ST_REG && cnt_q == 2'(CRA_REG_BYTES - 1))
          begin
            state_q <= is_wr_q ? CRA_ST_DATA : CRA_ST_END;
            cnt_q <= 2'h0;
          end
          else if (state_q == CRA_ST_DATA && cnt_q == 2'(CRA_DATA_BYTES - 1))
          begin
            state_q <= CRA_ST_END;
            cnt_q <= 2'h0;
          end
          else
            cnt_q <= cnt_q + 2'h1;
        end
        // anything but the end token is an overlong message
        CRA_ST_END:
          state_q <= CRA_ST_SKIP; // see [RULE14]
        // drop until the end token
        CRA_ST_SKIP:
          state_q <= CRA_ST_SKIP;
        default:
          state_q <= CRA_ST_IDLE;
      endcase
    end
  end

  // capture of command, destination and fields
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      is_wr_q <= 1'b0;
      rid_ok_q <= 1'b0;
      bank_q <= CRA_BANK_NONE;
      rid_q <= 24'h00_0000;
      reg_q <= 16'h0000;
      wdata_q <= 32'h0000_0000;
    end
    else if (acc && state_q == CRA_ST_IDLE)
    begin
      // any token in idle drops the old reply id, so a stray one gets no reply
      is_wr_q <= link.req_ctrl && link.req_data == CRA_TOK_WRITE;
      rid_ok_q <= 1'b0;
      bank_q <= bank_of(link.req_dest, tile_id_in, node_id_in);
    end
    else if (acc && !link.req_ctrl)
    begin
      // bytes arrive most significant first, see [RULE4]
      if (state_q == CRA_ST_RID)
      begin
        rid_q <= {rid_q[15:0], link.req_data};
        rid_ok_q <= cnt_q == 2'(CRA_RID_BYTES - 1);
      end
      if (state_q == CRA_ST_REG)
        reg_q <= {reg_q[7:0], link.req_data};
      if (state_q == CRA_ST_DATA)
        wdata_q <= {wdata_q[23:0], link.req_data};
    end
  end

  // register storage: written only by a good write, see [RULE14]
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      for (int i = 0; i < 3 * NREG; i++)
        mem_q[i] <= 32'h0000_0000;
    end
    else if (fin_ok && is_wr_q)
      mem_q[mem_idx] <= wdata_q; // see [RULE3] [RULE9]
  end

  // reply token sequencer
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      rsp_ok_q <= 1'b0;
      rsp_rd_q <= 1'b0;
      rsp_idx_q <= 3'h0;
      rsp_tok_q <= 9'h000;
      rsp_dest_q <= 24'h00_0000;
      rdata_q <= 32'h0000_0000;
    end
    else if (fin_reply)
    begin
      // first token is the status
      rsp_ok_q <= fin_ok;
      rsp_rd_q <= !is_wr_q;
      rsp_idx_q <= 3'h0;
      rsp_tok_q <= rsp_tok(3'h0, fin_ok, !is_wr_q, fin_ok ? mem_q[mem_idx] : 32'h0000_0000);
      rsp_dest_q <= rid_q;
      rdata_q <= fin_ok ? mem_q[mem_idx] : 32'h0000_0000;
    end
    else if (rsp_acc)
    begin
      // step to the next token
      rsp_idx_q <= rsp_idx_q + 3'h1;
      rsp_tok_q <= rsp_tok(rsp_idx_q + 3'h1, rsp_ok_q, rsp_rd_q, rdata_q);
    end
  end

  // user view of storage
  for (genvar g = 0; g < 3 * NREG; g++)
  begin : g_regs
    assign regs_out[g*32 +: 32] = mem_q[g];
  end
endmodule : cra_dev
`default_nettype wire

// [rtl/cra_host.sv]
// module: requester end that sends config messages and collects replies
`default_nettype none
module cra_host
  import cra_pkg::*;
(
  input wire logic core_clk_in, // system clock
  input wire logic srst_in, // synchronous reset, high
  cra_link_if.host link, // token link to handler
  input wire logic cmd_valid_in, // start a request
  output logic cmd_ready_out, // idle, request accepted
  input wire logic cmd_write_in, // 1 write, 0 read
  input wire logic [31:0] cmd_dest_in, // handler destination
  input wire logic [15:0] node_id_in, // own node id for reply
  input wire logic [7:0] chan_in, // own channel number for reply
  input wire logic [15:0] cmd_reg_in, // register number
  input wire logic [31:0] cmd_wdata_in, // write data
  input wire logic [15:0] ps_reg_in, // status register number
  output logic [31:0] ps_res_id_out, // status resource id
  output logic done_out, // request complete, one cycle
  output logic ok_out, // success of completed request
  output logic [31:0] rdata_out // read data of completed request
);
  import cra_pkg::*;

  // requester states
  typedef enum logic [1:0] {CRA_H_IDLE, CRA_H_SEND, CRA_H_WAIT} cra_host_state_t;

  cra_host_state_t state_q; // requester state
  logic wr_q; // request is a write
  logic [71:0] msg_q; // reply id, reg, data
  logic [3:0] idx_q; // request token index
  logic [8:0] tok_q; // request token {ctrl, value}
  logic [31:0] dest_q; // held destination
  logic [31:0] rdata_q; // collected read data
  logic ok_q; // success seen
  logic done_q; // completion pulse
  logic [31:0] ps_q; // status resource id
  logic start; // request accepted
  logic acc; // request token taken
  logic rsp_acc; // reply token taken
  logic [3:0] last; // last token index

  // request token at an index
  function automatic logic [8:0] req_tok(input logic [3:0] idx, input logic wr,
                                         input logic [71:0] msg);
    if (idx == 4'h0)
      return {1'b1, wr ? CRA_TOK_WRITE : CRA_TOK_READ}; // see [RULE9] [RULE13]
    else if (idx == (wr ? CRA_WR_LAST : CRA_RD_LAST))
      return {1'b1, CRA_TOK_END};
    else
      return {1'b0, msg[71 - 8 * (int'(idx) - 1) -: 8]}; // see [RULE4]
  endfunction : req_tok

  assign start = cmd_valid_in && state_q == CRA_H_IDLE;
  assign acc = link.req_valid && link.req_ready;
  assign rsp_acc = link.rsp_valid && link.rsp_ready;
  assign last = wr_q ? CRA_WR_LAST : CRA_RD_LAST;
  assign cmd_ready_out = state_q == CRA_H_IDLE;
  assign link.req_valid = state_q == CRA_H_SEND;
  assign link.req_ctrl = tok_q[8];
  assign link.req_data = tok_q[7:0];
  assign link.req_dest = dest_q;
  assign link.rsp_ready = state_q == CRA_H_WAIT;
  assign done_out = done_q;
  assign ok_out = ok_q;
  assign rdata_out = rdata_q;
  assign ps_res_id_out = ps_q;

  // status resource id: reg shifted left, ORed with type
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      ps_q <= 32'h0000_0000;
    else
      ps_q <= (32'(ps_reg_in) << CRA_PS_SHIFT) | 32'(CRA_PS_RES_TYPE); // see [RULE5]
  end

  // request sender and state
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state_q <= CRA_H_IDLE;
      wr_q <= 1'b0;
      msg_q <= 72'h00_0000_0000_0000_0000;
      idx_q <= 4'h0;
      tok_q <= 9'h000;
      dest_q <= 32'h0000_0000;
    end
    else if (start)
    begin
      // reply id is node then channel, see [RULE1] [RULE2]
      wr_q <= cmd_write_in;
      msg_q <= {node_id_in, chan_in, cmd_reg_in, cmd_wdata_in};
      idx_q <= 4'h0;
      tok_q <= req_tok(4'h0, cmd_write_in, 72'h00_0000_0000_0000_0000);
      dest_q <= cmd_dest_in; // see [RULE6] [RULE7] [RULE8]
      state_q <= CRA_H_SEND;
    end
    else if (state_q == CRA_H_SEND && acc)
    begin
      if (idx_q == last)
        // suppressed-reply write finishes at once, see [RULE3]
        state_q <= (wr_q && msg_q[55:48] == CRA_NOREPLY_CHAN) ? CRA_H_IDLE : CRA_H_WAIT;
      else
      begin
        idx_q <= idx_q + 4'h1;
        tok_q <= req_tok(idx_q + 4'h1, wr_q, msg_q);
      end
    end
    else if (state_q == CRA_H_WAIT && rsp_acc && link.rsp_ctrl
             && link.rsp_data == CRA_TOK_END)
      state_q <= CRA_H_IDLE;
  end

  // reply collector and completion
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      ok_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (state_q == CRA_H_SEND && acc && idx_q == last && wr_q
          && msg_q[55:48] == CRA_NOREPLY_CHAN)
      begin
        ok_q <= 1'b1;
        done_q <= 1'b1;
      end
      else if (state_q == CRA_H_WAIT && rsp_acc)
      begin
        if (link.rsp_ctrl && link.rsp_data == CRA_TOK_END)
          done_q <= 1'b1;
        else if (link.rsp_ctrl)
        begin
          // status token, see [RULE10] [RULE11] [RULE12]
          ok_q <= link.rsp_data == CRA_TOK_ACK;
          rdata_q <= 32'h0000_0000;
        end
        else
          rdata_q <= {rdata_q[23:0], link.rsp_data}; // see [RULE4]
      end
    end
  end
endmodule : cra_host
`default_nettype wire

// [tb/cra_link_props.sv]
// checker: token-level protocol properties on the requester to handler link
`default_nettype none
module cra_link_props
  import cra_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data,
  input wire logic [23:0] rsp_dest
);
  import cra_pkg::*;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);
  logic [3:0] idx_q; // tokens taken so far in this message
  logic [7:0] cmd_q; // command token of the message
  logic [23:0] rid_q; // reply id gathered from the message
  wire logic take = req_valid && req_ready; // request token moves
  wire logic fin = take && req_ctrl && (req_data == CRA_TOK_END); // end token moves
  wire logic rtake = rsp_valid && rsp_ready; // reply token moves
  // position inside the current request message
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in || fin)
    begin
      idx_q <= 4'h0;
    end
    else if (take)
    begin
      idx_q <= idx_q + 4'h1;
    end
  end
  // header capture: command token, then three reply id bytes
  always_ff @(posedge core_clk_in)
  begin
    if (take && idx_q == 4'h0)
    begin
      cmd_q <= req_data;
    end
    if (take && idx_q >= 4'h1 && idx_q <= 4'h3)
    begin
      rid_q <= {rid_q[15:0], req_data};
    end
  end
  chk_first_tok: assert property (take && idx_q == 4'h0 |-> req_ctrl &&
    (req_data == CRA_TOK_WRITE || req_data == CRA_TOK_READ)) else $error("bad first token");
  chk_write_len: assert property (fin && cmd_q == CRA_TOK_WRITE |-> idx_q == 4'hA)
    else $error("write message length wrong");
  chk_read_len: assert property (fin && cmd_q == CRA_TOK_READ |-> idx_q == 4'h6)
    else $error("read message length wrong");
  chk_reply_start: assert property (fin &&
    (cmd_q == CRA_TOK_READ || rid_q[7:0] != CRA_NOREPLY_CHAN)
    |=> rsp_valid && rsp_ctrl && (rsp_data == CRA_TOK_ACK || rsp_data == CRA_TOK_NAK))
    else $error("reply status missing");
  chk_no_reply: assert property (fin && cmd_q == CRA_TOK_WRITE &&
    rid_q[7:0] == CRA_NOREPLY_CHAN |=> !rsp_valid [*2])
    else $error("reply sent for silent write");
  chk_reply_end: assert property (rtake && rsp_ctrl && (rsp_data == CRA_TOK_NAK ||
    (rsp_data == CRA_TOK_ACK && cmd_q == CRA_TOK_WRITE))
    |-> ##[1:2] (rsp_valid && rsp_ctrl && rsp_data == CRA_TOK_END)) else $error("no end token");
  chk_read_word: assert property (rtake && rsp_ctrl && rsp_data == CRA_TOK_ACK &&
    cmd_q == CRA_TOK_READ |-> ##[1:2] (rsp_valid && !rsp_ctrl)) else $error("read data missing");
  chk_reply_dest: assert property (rsp_valid |-> rsp_dest == rid_q)
    else $error("reply destination wrong");
  // main scenarios
  cov_write: cover property (fin && cmd_q == CRA_TOK_WRITE);
  cov_nak: cover property (rtake && rsp_ctrl && rsp_data == CRA_TOK_NAK);
  cov_silent: cover property (fin && rid_q[7:0] == 8'hFF);
  cov_data: cover property (rtake && !rsp_ctrl);
endmodule : cra_link_props
`default_nettype wire

// [tb/cra_bench.sv]
// testbench: requester and handler joined, plus a lone handler fed bad messages
`default_nettype none
module cra_bench;
  import cra_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NR = 4; // registers per bank, small to reach the top
  logic clk, srst, cmd_valid, cmd_write, cmd_ready, done, ok, busy;
  logic [31:0] cmd_dest, cmd_wdata, ps_res, rdata;
  logic [15:0] hnode, cmd_reg, ps_reg, tile, node;
  logic [7:0] chan;
  logic [3*NR*32-1:0] regs1, regs2; // bank contents of both handlers
  logic [8:0] reqq[$], rspq[$], rsp2q[$], expq[$]; // {ctrl, value} tokens
  logic [31:0] mem[int]; // reference register storage
  logic [31:0] dsts[3];
  int err_count, num_checks, cyc;
  cra_link_if link1();
  cra_link_if link2();
  cra_host cra_host_inst (.core_clk_in(clk), .srst_in(srst), .link(link1),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_write_in(cmd_write),
    .cmd_dest_in(cmd_dest), .node_id_in(hnode), .chan_in(chan), .cmd_reg_in(cmd_reg),
    .cmd_wdata_in(cmd_wdata), .ps_reg_in(ps_reg), .ps_res_id_out(ps_res), .done_out(done),
    .ok_out(ok), .rdata_out(rdata));
  cra_dev #(.NREG(NR), .PERIPH_ID(8'h5A)) cra_dev_inst (.core_clk_in(clk), .srst_in(srst),
    .link(link1), .tile_id_in(tile), .node_id_in(node), .regs_out(regs1), .busy_out(busy));
  cra_dev #(.NREG(NR), .PERIPH_ID(8'h5A)) cra_dev_inst_2 (.core_clk_in(clk), .srst_in(srst),
    .link(link2), .tile_id_in(tile), .node_id_in(node), .regs_out(regs2), .busy_out());
  cra_link_props cra_link_props_inst (.core_clk_in(clk), .srst_in(srst),
    .req_valid(link1.req_valid), .req_ready(link1.req_ready), .req_ctrl(link1.req_ctrl),
    .req_data(link1.req_data), .rsp_valid(link1.rsp_valid), .rsp_ready(link1.rsp_ready),
    .rsp_ctrl(link1.rsp_ctrl), .rsp_data(link1.rsp_data), .rsp_dest(link1.rsp_dest));
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // verdict and end of run
  task automatic final_report();
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // single value comparison
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  // token stream comparison
  task automatic cmp_q(input string what, input logic [8:0] e[$], input logic [8:0] g[$]);
    cmp({what, " count"}, e.size(), g.size());
    foreach (e[i])
      if (i < g.size())
        cmp(what, 32'(e[i]), 32'(g[i]));
  endtask : cmp_q
  // link monitor and hang guard
  always @(posedge clk)
  begin
    if (link1.req_valid && link1.req_ready)
      reqq.push_back({link1.req_ctrl, link1.req_data});
    if (link1.rsp_valid && link1.rsp_ready)
      rspq.push_back({link1.rsp_ctrl, link1.rsp_data});
    if (link2.rsp_valid && link2.rsp_ready)
      rsp2q.push_back({link2.rsp_ctrl, link2.rsp_data});
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  // one command through the requester, checked against the reference
  task automatic do_op(input logic wr, input int b, input logic [7:0] ch,
    input logic [15:0] rg, input logic [31:0] wd);
    int n;
    logic good;
    logic [31:0] erd;
    logic [71:0] body; // reply id, register, data
    logic [1:0] saw; // busy seen, ready low seen
    good = (b < 3) && (rg < NR);
    saw = 2'b00;
    erd = 32'h0000_0000;
    reqq.delete();
    rspq.delete();
    expq.delete();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_dest <= (b < 3) ? dsts[b] : {tile, 16'h1234};
    chan <= ch;
    cmd_reg <= rg;
    cmd_wdata <= wd;
    hnode <= 16'($urandom);
    ps_reg <= 16'($urandom);
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      saw = saw | {busy, !cmd_ready};
    end
    while (done !== 1'b1 && n < 200);
    cmp("done", 32'h1, {31'h0, done});
    if (good && wr)
      mem[b * NR + int'(rg)] = wd;
    if (good && !wr && mem.exists(b * NR + int'(rg)))
      erd = mem[b * NR + int'(rg)];
    body = {hnode, ch, rg, wd};
    expq.push_back({1'b1, wr ? CRA_TOK_WRITE : CRA_TOK_READ});
    for (int i = 0; i < (wr ? 9 : 5); i++)
      expq.push_back({1'b0, body[71 - 8 * i -: 8]});
    expq.push_back({1'b1, CRA_TOK_END});
    cmp_q("request", expq, reqq);
    expq.delete();
    if (!(wr && ch == 8'hFF))
    begin
      expq.push_back({1'b1, good ? CRA_TOK_ACK : CRA_TOK_NAK});
      if (good && !wr)
        for (int i = 0; i < 4; i++)
          expq.push_back({1'b0, erd[31 - 8 * i -: 8]});
      expq.push_back({1'b1, CRA_TOK_END});
    end
    cmp_q("reply", expq, rspq);
    cmp("ok", {31'h0, good || (wr && ch == 8'hFF)}, {31'h0, ok});
    if (!wr)
      cmp("rdata", erd, rdata);
    cmp("ps id", {8'h00, ps_reg, 8'h0B}, ps_res);
    for (int i = 0; i < 3 * NR; i++)
      cmp("reg", mem.exists(i) ? mem[i] : 32'h0000_0000, regs1[i * 32 +: 32]);
    cmp("busy seen", 32'h3, {30'h0, saw});
    cmp("idle after", 32'h1, {30'h0, busy, cmd_ready});
  endtask : do_op
  // one token offered on the second link, held until taken
  task automatic put_tok(input logic [8:0] t);
    int n;
    @(posedge clk);
    link2.req_valid <= 1'b1;
    {link2.req_ctrl, link2.req_data} <= t;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (link2.req_ready !== 1'b1 && n < 50);
  endtask : put_tok
  // malformed messages: early end, control token inside the register field
  logic [8:0] bad[2][7] = '{'{9'h1C0, 9'h000, 9'h011, 9'h022, 9'h000, 9'h001, 9'h101},
    '{9'h1C1, 9'h000, 9'h011, 9'h022, 9'h103, 9'h002, 9'h101}};
  initial
  begin
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    srst = 1'b1;
    {cmd_valid, cmd_write, chan, cmd_reg, ps_reg, hnode} = '0;
    cmd_dest = 32'h0000_0000;
    cmd_wdata = 32'h0000_0000;
    tile = 16'h3A10;
    node = 16'h7001;
    dsts = '{{16'h3A10, CRA_TILE_CODE}, {16'h7001, CRA_NODE_CODE}, {16'h7001, 8'h5A, 8'h02}};
    link2.req_valid = 1'b0;
    link2.req_ctrl = 1'b0;
    link2.req_data = 8'h00;
    link2.req_dest = {16'h3A10, CRA_TILE_CODE};
    link2.rsp_ready = 1'b1;
    void'($urandom(7549));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int b = 0; b < 3; b++)
    begin
      do_op(1'b1, b, 8'h21, 16'(NR - 1), 32'hA5A5_0000 + b);
      do_op(1'b0, b, 8'h21, 16'(NR - 1), 32'h0000_0000);
      do_op(1'b1, b, 8'h21, 16'(NR), 32'hFFFF_FFFF);
      do_op(1'b0, b, 8'h21, 16'(NR), 32'h0000_0000);
      do_op(1'b1, b, 8'hFF, 16'h0000, 32'h1234_5678 ^ b);
    end
    do_op(1'b1, 3, 8'h21, 16'h0000, 32'h0000_0001);
    repeat (30)
      do_op(1'($urandom_range(0, 1)), $urandom_range(0, 2), 8'($urandom),
        16'($urandom_range(0, NR)), $urandom);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    mem.delete();
    do_op(1'b0, 0, 8'h07, 16'h0000, 32'h0000_0000);
    for (int m = 0; m < 2; m++)
    begin
      rsp2q.delete();
      foreach (bad[m][k])
        put_tok(bad[m][k]);
      @(posedge clk);
      link2.req_valid <= 1'b0;
      link2.req_data <= ~link2.req_data;
      repeat (20) @(negedge clk);
      cmp_q("bad reply", '{{1'b1, CRA_TOK_NAK}, {1'b1, CRA_TOK_END}}, rsp2q);
    end
    // stray data token in idle, then end: reply id never complete, so silence
    expq.delete();
    rsp2q.delete();
    put_tok(9'h033);
    put_tok({1'b1, CRA_TOK_END});
    @(posedge clk);
    link2.req_valid <= 1'b0;
    repeat (20) @(negedge clk);
    cmp_q("stray reply", expq, rsp2q);
    for (int i = 0; i < 3 * NR; i++)
      cmp("bad reg", 32'h0000_0000, regs2[i * 32 +: 32]);
    final_report();
  end
endmodule : cra_bench
`default_nettype wire
